// ---- rtl/ofwd_top.sv ----
// CSI-2 output forwarding: per-port packet buffers, two forwarding
// engines, output state control, status and line statistics.
// Assumes link signals are asynchronous and change well before the
// rising edge of their own link clock, and register port is same-clock.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////
// Packet FIFO; DEPTH must be a power of two
module ofwd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Fill side
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  // Drain side
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // Storage, no reset needed
  logic [AW:0] wp_q; // Write pointer with wrap bit
  logic [AW:0] rp_q; // Read pointer with wrap bit
  logic full;
  logic empty;

  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty = (wp_q == rp_q);
  assign wr_ready_out = ~full;
  assign rd_valid_out = ~empty;
  assign rd_data_out = mem[rp_q[AW-1:0]];

  // Store a word when there is room
  always_ff @(posedge clk_in)
  begin
    if (ce_in && wr_valid_in && !full)
    begin
      mem[wp_q[AW-1:0]] <= wr_data_in;
    end
  end

  // Pointer update
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else if (ce_in)
    begin
      if (wr_valid_in && !full)
        wp_q <= wp_q + 1'b1;
      if (rd_ready_in && !empty)
        rp_q <= rp_q + 1'b1;
    end
  end
endmodule : ofwd_fifo

////////////////////////////////////////////////////////////////////////
module ofwd_top
  import ofwd_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Power-down pin, low means powered down
  input wire logic power_down_pin_n_in,
  // Receive ports
  input wire ofwd_rx_t [1:0] rx_in,
  output logic [1:0] rx_ready_out,
  // CSI-2 outputs and status
  output ofwd_tx_t [1:0] tx_out,
  output logic [1:0] pass_gpio_out,
  output logic status_change_out
);
  // Registers
  logic [7:0] gen_q; // general_configuration
  logic [7:0] fwdp_q; // forwarding_port_control
  logic [7:0] fwdm_q; // forwarding_mode_control
  logic [7:0] txc_q; // transmitter_control
  logic [7:0] page_q; // indirect_page_control
  logic [7:0] idx_q; // indirect_index
  logic [7:0] tim_q [9]; // Timing override values
  logic [7:0] sts_q; // transmitter_status
  logic [7:0] rd_d;
  // Receive side
  ofwd_rx_t [1:0] s1_q, s2_q, s3_q, f_q; // Sync stages, filtered
  logic [1:0] lclk_prev_q;
  logic [1:0] push, wr_rdy, rd_rdy, rd_vld, avail;
  logic [OFWD_WORD_W-1:0] rd_dat [2];
  logic [14:0] pkt_cnt_q [2]; // Complete packets stored
  logic [1:0] map; // Output that owns each port
  logic [1:0] lock_f, err_f;
  // Engines and outputs
  ofwd_eng_t eng_q [2];
  logic sel_q [2]; // Port being served
  logic rr_q [2]; // Port served last
  ofwd_tx_t [1:0] txd;
  logic [1:0] pass_d, sync_d;
  logic [7:0] sts_d;
  logic rep;
  // Line statistics
  logic first_q;
  logic [15:0] acc_q, lcnt_q, llen_q;
  logic tim_hit;

  assign rep = fwdm_q[OFWD_MODE_REP_BIT];
  assign tim_hit = (page_q[4:2] == OFWD_PAGE_TIMING) &&
                   (idx_q[7:4] == OFWD_TIM_BANK) &&
                   (idx_q[3:0] < OFWD_TIM_COUNT);

  //////////////////////////////////////////////////////////////////////
  // Receive ports: synchroniser, buffer, packet tally
  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_rx
      // Three stages, then keep a bit only once two stages agree
      always_ff @(posedge clk_in)
      begin
        if (reset_in)
        begin
          s1_q[p] <= '0;
          s2_q[p] <= '0;
          s3_q[p] <= '0;
          f_q[p] <= '0;
          lclk_prev_q[p] <= 1'b0;
          rx_ready_out[p] <= 1'b0;
        end
        else if (ce_in)
        begin
          s1_q[p] <= rx_in[p];
          s2_q[p] <= s1_q[p];
          s3_q[p] <= s2_q[p];
          f_q[p] <= (s2_q[p] & s3_q[p]) | (f_q[p] & (s2_q[p] | s3_q[p]));
          lclk_prev_q[p] <= f_q[p].lclk;
          rx_ready_out[p] <= wr_rdy[p];
        end
      end

      // Byte taken on the filtered rising edge of the link clock
      assign push[p] = f_q[p].lclk & ~lclk_prev_q[p] & f_q[p].valid;
      assign lock_f[p] = f_q[p].lock;
      assign err_f[p] = f_q[p].err;
      // Replicate pins every port on output zero
      assign map[p] = rep ? 1'b0 : fwdp_q[OFWD_FWD_MAP_LSB+p];
      // Drain only for the single engine that owns this buffer
      assign rd_rdy[p] = (eng_q[map[p]] == OFWD_E_SEND) &&
                         (sel_q[map[p]] == 1'(p));
      assign avail[p] = (pkt_cnt_q[p] != 15'h0000);

      ofwd_fifo #(
        .WIDTH(OFWD_WORD_W),
        .DEPTH(OFWD_BUF_BYTES)
      ) u_buf (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .wr_valid_in(push[p]),
        .wr_ready_out(wr_rdy[p]),
        .wr_data_in({f_q[p].last, f_q[p].data}),
        .rd_valid_out(rd_vld[p]),
        .rd_ready_in(rd_rdy[p]),
        .rd_data_out(rd_dat[p])
      );

      // Whole packets held; a packet counts once its last byte lands
      always_ff @(posedge clk_in)
      begin
        if (reset_in)
          pkt_cnt_q[p] <= '0;
        else if (ce_in)
          pkt_cnt_q[p] <= 15'(pkt_cnt_q[p]
            + {14'h0000, push[p] & wr_rdy[p] & f_q[p].last}
            - {14'h0000, rd_vld[p] & rd_rdy[p] & rd_dat[p][8]});
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Forwarding engines and output state per CSI-2 port
  genvar t;
  generate
    for (t = 0; t < 2; t++)
    begin : g_tx
      logic [1:0] mapped, own, ready;
      logic act, fwd_on, pick;
      ofwd_pin_t pin;

      assign mapped = {map[1] == 1'(t), map[0] == 1'(t)};
      assign own = mapped & ~fwdp_q[OFWD_FWD_DIS_LSB+:2];
      assign ready = own & avail;
      assign act = |(mapped & lock_f);
      assign fwd_on = |own;
      // Alternate when both buffers hold a packet
      assign pick = (ready == 2'b11) ? ~rr_q[t] : ready[1];

      // Pin state, first match wins
      always_comb
      begin
        if (!power_down_pin_n_in)
          pin = OFWD_PIN_HIZ;
        else if (!gen_q[OFWD_GEN_OSS_BIT])
          pin = OFWD_PIN_HS0;
        else if (!gen_q[OFWD_GEN_OEN_BIT])
          pin = OFWD_PIN_HIZ;
        else if (!txc_q[OFWD_TXC_EN_BIT])
          pin = OFWD_PIN_HIZ; // Transmitter off
        else if (!act)
          pin = gen_q[OFWD_GEN_OEM_BIT] ? OFWD_PIN_LP11
                                        : OFWD_PIN_HIZ;
        else if (!fwd_on)
          pin = OFWD_PIN_LP11;
        else
          pin = OFWD_PIN_VALID;
      end

      // Engine: wait for a packet, LP-to-HS, send, HS-to-LP
      always_ff @(posedge clk_in)
      begin
        if (reset_in)
        begin
          eng_q[t] <= OFWD_E_IDLE;
          sel_q[t] <= 1'b0;
          rr_q[t] <= 1'b1;
        end
        else if (ce_in)
        begin
          unique case (eng_q[t])
            OFWD_E_IDLE:
            begin
              // Start only with traffic allowed on the pins
              if (pin == OFWD_PIN_VALID && ready != 2'b00)
              begin
                sel_q[t] <= pick;
                eng_q[t] <= OFWD_E_SOT;
              end
            end
            OFWD_E_SOT:
              eng_q[t] <= OFWD_E_SEND;
            OFWD_E_SEND:
            begin
              // A whole packet is stored, so it drains without gaps
              if (rd_vld[sel_q[t]] && rd_dat[sel_q[t]][8])
                eng_q[t] <= OFWD_E_EOT;
            end
            OFWD_E_EOT:
            begin
              rr_q[t] <= sel_q[t];
              eng_q[t] <= OFWD_E_IDLE;
            end
          endcase
        end
      end

      // Next output value of this port
      always_comb
      begin
        txd[t].pin = pin;
        txd[t].hs = (pin == OFWD_PIN_VALID) &&
                    (eng_q[t] inside {OFWD_E_SOT, OFWD_E_SEND});
        txd[t].clk_lane = txd[t].hs;
        txd[t].dvalid = (eng_q[t] == OFWD_E_SEND) && rd_vld[sel_q[t]];
        txd[t].data = txd[t].dvalid ? rd_dat[sel_q[t]][7:0] : 8'h00;
      end

      // Pass needs traffic allowed and no video error on its inputs
      assign pass_d[t] = (pin == OFWD_PIN_VALID) && !(|(mapped & err_f));
      // Sync needs its enable and both sources locked and owned
      assign sync_d[t] = fwdm_q[OFWD_MODE_SYNC_LSB+t] && pass_d[t] &&
                         (own == 2'b11) && (lock_f == 2'b11);
    end
  endgenerate

  // Output registers; in replicate output one mirrors output zero with its clock lane held on
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      tx_out <= {2{OFWD_PIN_HIZ, 11'h000}};
    end
    else if (ce_in)
    begin
      tx_out[0] <= txd[0];
      if (rep)
      begin
        tx_out[1] <= txd[0];
        tx_out[1].clk_lane <= 1'b1;
      end
      else
        tx_out[1] <= txd[1];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Status register, GPIO copy and change event
  assign sts_d = {4'h0, sync_d[1], pass_d[1], sync_d[0], pass_d[0]};

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      sts_q <= OFWD_ZERO_RST;
      pass_gpio_out <= 2'b00;
      status_change_out <= 1'b0;
    end
    else if (ce_in)
    begin
      sts_q <= sts_d;
      pass_gpio_out <= pass_d;
      status_change_out <= (sts_d != sts_q);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Line statistics on one chosen port; several channels on the
  // port interleave and corrupt the figures
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      first_q <= 1'b1;
      acc_q <= '0;
      lcnt_q <= '0;
      llen_q <= '0;
    end
    else if (ce_in && push[gen_q[OFWD_GEN_STAT_BIT]])
    begin
      first_q <= f_q[gen_q[OFWD_GEN_STAT_BIT]].last;
      acc_q <= first_q ? 16'h0001 : 16'(acc_q + 16'h0001);
      // Frame start short packet restarts the tally
      if (first_q && !f_q[gen_q[OFWD_GEN_STAT_BIT]].long_pkt &&
          f_q[gen_q[OFWD_GEN_STAT_BIT]].data[5:0] == OFWD_DT_FS)
        lcnt_q <= '0;
      else if (f_q[gen_q[OFWD_GEN_STAT_BIT]].long_pkt &&
               f_q[gen_q[OFWD_GEN_STAT_BIT]].last)
      begin
        lcnt_q <= 16'(lcnt_q + 16'h0001);
        llen_q <= 16'(acc_q + 16'h0001 - OFWD_PKT_OVH);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register writes and the indirect timing window
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      gen_q <= OFWD_GEN_RST;
      fwdp_q <= OFWD_FWDP_RST;
      fwdm_q <= OFWD_ZERO_RST;
      txc_q <= OFWD_ZERO_RST;
      page_q <= OFWD_ZERO_RST;
      idx_q <= OFWD_ZERO_RST;
      for (int i = 0; i < 9; i++)
        tim_q[i] <= OFWD_ZERO_RST;
    end
    else if (ce_in && reg_wr_in)
    begin
      unique case (reg_addr_in)
        OFWD_GEN_ADDR: gen_q <= reg_wdata_in;
        OFWD_FWDP_ADDR: fwdp_q <= reg_wdata_in;
        OFWD_FWDM_ADDR: fwdm_q <= reg_wdata_in;
        OFWD_TXC_ADDR: txc_q <= reg_wdata_in;
        OFWD_PAGE_ADDR: page_q <= reg_wdata_in;
        OFWD_INDEX_ADDR: idx_q <= reg_wdata_in;
        OFWD_DATA_ADDR:
        begin
          if (tim_hit)
            tim_q[idx_q[3:0]] <= reg_wdata_in;
          if (page_q[OFWD_PAGE_AINC_BIT])
            idx_q <= 8'(idx_q + 8'h01);
        end
        default: ; // Other writes are ignored
      endcase
    end
    else if (ce_in && reg_rd_in && reg_addr_in == OFWD_DATA_ADDR &&
             page_q[OFWD_PAGE_AINC_BIT])
      idx_q <= 8'(idx_q + 8'h01);
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb
  begin
    unique case (reg_addr_in)
      OFWD_GEN_ADDR: rd_d = gen_q;
      OFWD_FWDP_ADDR: rd_d = fwdp_q;
      OFWD_FWDM_ADDR: rd_d = fwdm_q;
      OFWD_TXC_ADDR: rd_d = txc_q;
      OFWD_STS_ADDR: rd_d = sts_q;
      OFWD_LCNT_HI_ADDR: rd_d = lcnt_q[15:8];
      OFWD_LCNT_LO_ADDR: rd_d = lcnt_q[7:0];
      OFWD_LLEN_HI_ADDR: rd_d = llen_q[15:8];
      OFWD_LLEN_LO_ADDR: rd_d = llen_q[7:0];
      OFWD_PAGE_ADDR: rd_d = page_q;
      OFWD_INDEX_ADDR: rd_d = idx_q;
      OFWD_DATA_ADDR: rd_d = tim_hit ? tim_q[idx_q[3:0]] : 8'h00;
      default: rd_d = 8'h00;
    endcase
  end

  // Read data registered, one cycle after the strobe
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end
    else if (ce_in)
    begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in)
        reg_rdata_out <= rd_d;
    end
  end
endmodule : ofwd_top

// ---- rtl/ofwd_pkg.sv ----
// Package of the CSI-2 output forwarding block: register map, field
// positions, reset values, carrier structs and state encodings.
// Assumes one register port, two receive ports and two CSI-2 outputs.
package ofwd_pkg;
  // Register offsets
  localparam logic [7:0] OFWD_GEN_ADDR = 8'h02;
  localparam logic [7:0] OFWD_FWDP_ADDR = 8'h20;
  localparam logic [7:0] OFWD_FWDM_ADDR = 8'h21;
  localparam logic [7:0] OFWD_TXC_ADDR = 8'h33;
  localparam logic [7:0] OFWD_STS_ADDR = 8'h35;
  localparam logic [7:0] OFWD_LCNT_HI_ADDR = 8'h73;
  localparam logic [7:0] OFWD_LCNT_LO_ADDR = 8'h74;
  localparam logic [7:0] OFWD_LLEN_HI_ADDR = 8'h75;
  localparam logic [7:0] OFWD_LLEN_LO_ADDR = 8'h76;
  localparam logic [7:0] OFWD_PAGE_ADDR = 8'hB0;
  localparam logic [7:0] OFWD_INDEX_ADDR = 8'hB1;
  localparam logic [7:0] OFWD_DATA_ADDR = 8'hB2;
  // Reset values
  localparam logic [7:0] OFWD_GEN_RST = 8'h03;
  localparam logic [7:0] OFWD_FWDP_RST = 8'h03;
  localparam logic [7:0] OFWD_ZERO_RST = 8'h00;
  // Field positions
  localparam int OFWD_GEN_OEN_BIT = 0;
  localparam int OFWD_GEN_OSS_BIT = 1;
  localparam int OFWD_GEN_OEM_BIT = 2;
  localparam int OFWD_GEN_STAT_BIT = 3;
  localparam int OFWD_FWD_DIS_LSB = 0;
  localparam int OFWD_FWD_MAP_LSB = 4;
  localparam int OFWD_MODE_SYNC_LSB = 2;
  localparam int OFWD_MODE_REP_BIT = 7;
  localparam int OFWD_TXC_EN_BIT = 0;
  localparam int OFWD_PAGE_AINC_BIT = 1;
  localparam logic [2:0] OFWD_PAGE_TIMING = 3'h0;
  localparam logic [3:0] OFWD_TIM_BANK = 4'h4;
  localparam logic [3:0] OFWD_TIM_COUNT = 4'h9;
  // Buffer sizes and packet overhead
  localparam int OFWD_BUF_BYTES = 16384;
  localparam int OFWD_WORD_W = 9;
  localparam logic [15:0] OFWD_PKT_OVH = 16'h0006;
  localparam logic [5:0] OFWD_DT_FS = 6'h00;
  // One receive-port sample as it arrives from the link
  typedef struct packed {
    logic lclk;
    logic lock;
    logic err;
    logic valid;
    logic last;
    logic long_pkt;
    logic [7:0] data;
  } ofwd_rx_t;
  // CSI-2 pin states
  typedef enum logic [3:0] {
    OFWD_PIN_HIZ = 4'b0001,
    OFWD_PIN_HS0 = 4'b0010,
    OFWD_PIN_LP11 = 4'b0100,
    OFWD_PIN_VALID = 4'b1000
  } ofwd_pin_t;
  // One CSI-2 output port
  typedef struct packed {
    ofwd_pin_t pin;
    logic hs;
    logic clk_lane;
    logic dvalid;
    logic [7:0] data;
  } ofwd_tx_t;
  // Forwarding engine states
  typedef enum logic [3:0] {
    OFWD_E_IDLE = 4'b0001,
    OFWD_E_SOT = 4'b0010,
    OFWD_E_SEND = 4'b0100,
    OFWD_E_EOT = 4'b1000
  } ofwd_eng_t;
endpackage : ofwd_pkg

// ---- test/ofwd_top_asserts.sv ----
// Port-level checker of the forwarding block.
// Assumes ce_in stays high and one clock domain.
`timescale 1ns/100ps
module ofwd_top_asserts
  import ofwd_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic reg_rvalid_out,
  // Pins and status
  input wire logic power_down_pin_n_in,
  input wire ofwd_tx_t [1:0] tx_out,
  input wire logic [1:0] pass_gpio_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////
  // Shadow of the replicate bit, which is not visible at the ports
  logic rep_q;
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      rep_q <= 1'b0;
    else if (reg_wr_in && reg_addr_in == OFWD_FWDM_ADDR)
      rep_q <= reg_wdata_in[OFWD_MODE_REP_BIT];
  end
  // Burst opens: idle, then high speed
  sequence burst_open;
    !tx_out[0].hs ##1 tx_out[0].hs;
  endsequence
  // Read request not overridden by a write
  sequence rd_taken;
    reg_rd_in && !reg_wr_in;
  endsequence
  ////////////////////////////////////////
  chk_read_answer: assert property (rd_taken |=> reg_rvalid_out)
    else $error("read not answered next cycle");
  chk_read_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in))
    else $error("read answer without request");
  chk_pd_hiz: assert property ((!power_down_pin_n_in) [*2] |->
    tx_out[0].pin == OFWD_PIN_HIZ && tx_out[1].pin == OFWD_PIN_HIZ)
    else $error("pins driven while powered down");
  chk_sot_gap: assert property (burst_open |->
    !tx_out[0].dvalid ##1 tx_out[0].dvalid)
    else $error("burst start framing wrong");
  chk_eot_after: assert property ($fell(tx_out[0].hs) |->
    $past(tx_out[0].dvalid))
    else $error("burst closed without final byte");
  chk_byte_in_hs: assert property (tx_out[0].dvalid |-> tx_out[0].hs)
    else $error("byte outside burst");
  chk_hs_valid: assert property (tx_out[0].hs |->
    tx_out[0].pin == OFWD_PIN_VALID)
    else $error("burst while pins not valid");
  chk_rep_copy: assert property (rep_q && $past(rep_q, 2) &&
    tx_out[0].dvalid |-> tx_out[1].dvalid &&
    tx_out[1].data == tx_out[0].data)
    else $error("second output not a copy");
  chk_rep_clock: assert property (rep_q && $past(rep_q, 2) |->
    tx_out[1].clk_lane)
    else $error("second clock lane off");
  chk_pass_drop: assert property ((tx_out[0].pin != OFWD_PIN_VALID) [*2]
    |-> !pass_gpio_out[0])
    else $error("pass set without valid output");
endmodule : ofwd_top_asserts

bind ofwd_top ofwd_top_asserts u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_rvalid_out(reg_rvalid_out),
  .power_down_pin_n_in(power_down_pin_n_in), .tx_out(tx_out),
  .pass_gpio_out(pass_gpio_out));

// ---- test/ofwd_sink.sv ----
// Downstream receiver model: tallies bytes of high-speed bursts.
// Assumes one output port struct on the block's clock.
`timescale 1ns/100ps
module ofwd_sink
  import ofwd_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Watched output port
  input wire ofwd_tx_t tx_in,
  // Tallies
  output int n_out,
  output logic [15:0] sum_out
);
  // Bytes count only inside a burst, as a real receiver would
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      n_out <= 0;
      sum_out <= 16'h0000;
    end
    else if (tx_in.dvalid && tx_in.hs)
    begin
      n_out <= n_out + 1;
      sum_out <= sum_out + 16'(tx_in.data);
    end
  end
endmodule : ofwd_sink

// ---- test/tb.sv ----
// Testbench of the forwarding block, buffers reached through the top.
// Assumes the checker is bound and two sink models watch the outputs.
`timescale 1ns/100ps
module tb
  import ofwd_pkg::*;
;
  localparam logic [7:0] RA [8] = '{8'h02, 8'h20, 8'h21, 8'h35, 8'h73,
    8'h74, 8'h76, 8'h55};
  localparam logic [7:0] RE [8] = '{8'h03, 8'h03, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00};
  // Pin table rows: config, forwarding, locks, expected pin state
  localparam logic [7:0] PG [6] = '{8'h01, 8'h02, 8'h03, 8'h07, 8'h03,
    8'h03};
  localparam logic [7:0] PF [6] = '{8'h03, 8'h03, 8'h03, 8'h03, 8'h03,
    8'h00};
  localparam logic [5:0] L0 = 6'b100000;
  localparam logic [5:0] L1 = 6'b110000;
  localparam ofwd_pin_t PE [6] = '{OFWD_PIN_HS0, OFWD_PIN_HIZ,
    OFWD_PIN_HIZ, OFWD_PIN_LP11, OFWD_PIN_LP11, OFWD_PIN_VALID};
  localparam logic [7:0] TIM [9] = '{8'h83, 8'h8D, 8'h87, 8'h87, 8'h83,
    8'h86, 8'h84, 8'h86, 8'h84};
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pdn = 1'b1;
  ofwd_rx_t [1:0] rx = '0;
  logic [7:0] rdata;
  logic rvalid;
  logic [1:0] rx_rdy;
  logic [1:0] gpio;
  ofwd_tx_t [1:0] tx;
  logic evt;
  int n0;
  int n1;
  logic [15:0] s0;
  logic [15:0] s1;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  int evt_n = 0;
  ofwd_top dut (.clk_in(clk_in), .reset_in(reset_in), .ce_in(1'b1),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .power_down_pin_n_in(pdn), .rx_in(rx), .rx_ready_out(rx_rdy),
    .tx_out(tx), .pass_gpio_out(gpio), .status_change_out(evt));
  ofwd_sink sink0 (.clk_in(clk_in), .reset_in(reset_in), .tx_in(tx[0]),
    .n_out(n0), .sum_out(s0));
  ofwd_sink sink1 (.clk_in(clk_in), .reset_in(reset_in), .tx_in(tx[1]),
    .n_out(n1), .sum_out(s1));
  always #10 clk_in = ~clk_in;
  ////////////////////////////////////////
  task automatic end_of_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test
  task automatic check(input string nm, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // Status events counted; run cut short if it hangs
  always @(posedge clk_in)
  begin
    cyc++;
    if (evt === 1'b1)
      evt_n++;
    if (cyc == 5000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic wreg(input logic [7:0] a, d);
    @(posedge clk_in) #1;
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk_in) #1;
    wr = 1'b0;
  endtask : wreg
  // Read answer stands only in the cycle after the strobe is taken
  task automatic expect_reg(input logic [7:0] a, e);
    @(posedge clk_in) #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk_in) #1;
    rd = 1'b0;
    check("rvalid", rvalid, 1'b1);
    check($sformatf("reg %h", a), rdata, e);
  endtask : expect_reg
  // One link byte: fields settle while the link clock is low
  task automatic lbyte(input logic [7:0] d, input logic last);
    rx[0].valid = 1'b1;
    rx[0].data = d;
    rx[0].last = last;
    rx[0].long_pkt = 1'b1;
    repeat (4) @(posedge clk_in) #1;
    rx[0].lclk = 1'b1;
    repeat (4) @(posedge clk_in) #1;
    rx[0].lclk = 1'b0;
  endtask : lbyte
  task automatic pkt(input int n, input logic [7:0] b,
    output logic [15:0] e);
    int c;
    c = n0;
    e = 16'h0000;
    for (int i = 0; i < n; i++)
    begin
      if (i == n - 1)
      begin
        repeat (20) @(posedge clk_in) #1;
        check("held", 16'(n0), 16'(c));
      end
      lbyte(b + 8'(i), i == n - 1);
      e = e + 16'(b + 8'(i));
    end
    // Released line shows the inverse of its last value
    rx[0].valid = 1'b0;
    rx[0].data = ~rx[0].data;
    for (int k = 0; k < 200 && n0 != c + n; k++)
      @(posedge clk_in) #1;
    check("count", 16'(n0 - c), 16'(n));
  endtask : pkt
  ////////////////////////////////////////
  initial
  begin
    logic [15:0] e1;
    logic [15:0] e2;
    int na;
    repeat (2) @(posedge clk_in) #1;
    reset_in = 1'b0;
    wreg(8'h35, 8'hFF);
    for (int i = 0; i < 8; i++)
      expect_reg(RA[i], RE[i]);
    wreg(8'h33, 8'h01);
    for (int i = 0; i < 6; i++)
    begin
      wreg(8'h02, PG[i]);
      wreg(8'h20, PF[i]);
      rx[0].lock = L0[i];
      rx[1].lock = L1[i];
      repeat (10) @(posedge clk_in) #1;
      check("pin", tx[0].pin, PE[i]);
    end
    expect_reg(8'h35, 8'h01);
    check("gpio", gpio, 2'b01);
    rx[0].err = 1'b1;
    repeat (10) @(posedge clk_in) #1;
    expect_reg(8'h35, 8'h00);
    check("events", 16'(evt_n), 16'd2);
    rx[0].err = 1'b0;
    pdn = 1'b0;
    repeat (3) @(posedge clk_in) #1;
    check("pd pin", tx[0].pin, OFWD_PIN_HIZ);
    pdn = 1'b1;
    repeat (10) @(posedge clk_in) #1;
    pkt(10, 8'h10, e1);
    check("sum0", s0, e1);
    expect_reg(8'h74, 8'h01);
    expect_reg(8'h76, 8'h04);
    // Replicating: output one copies the burst and keeps its clock lane high
    wreg(8'h21, 8'h80);
    pkt(12, 8'h40, e2);
    check("sum1", s1, e2);
    check("n1", 16'(n1), 16'd12);
    check("clk lane", tx[1].clk_lane, 1'b1);
    expect_reg(8'h73, 8'h00);
    expect_reg(8'h74, 8'h02);
    expect_reg(8'h76, 8'h06);
    wreg(8'hB0, 8'h02);
    wreg(8'hB1, 8'h40);
    for (int i = 0; i < 9; i++)
      wreg(8'hB2, TIM[i]);
    wreg(8'hB1, 8'h40);
    for (int i = 0; i < 9; i++)
      expect_reg(8'hB2, TIM[i]);
    // Port held off: its packet waits whole in its own buffer
    wreg(8'h20, 8'h01);
    na = n0;
    e1 = s0;
    for (int i = 0; i < 6; i++)
      lbyte(8'h60 + 8'(i), i == 5);
    rx[0].valid = 1'b0;
    repeat (30) @(posedge clk_in) #1;
    check("parked", 16'(n0 - na), 16'h0000);
    check("room", 16'(rx_rdy), 16'h0003);
    wreg(8'h20, 8'h00);
    repeat (30) @(posedge clk_in) #1;
    check("released", 16'(n0 - na), 16'h0006);
    check("released sum", 16'(s0 - e1), 16'h024F);
    end_of_test();
  end
endmodule : tb
